// file: verilog/seep_pkg.sv
// constants and types of the serial nonvolatile memory command port
package seep_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 20;
  localparam int CS_LOW_NS       = 250;
  localparam int CS_LOW_CYCLES   = (CS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_TIME_NS    = 10000000;
  localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // geometry and encodings
  // ----------------------------------------------------------------
  localparam int         WORDS        = 128;
  localparam logic [4:0] ADDR_LEN_X16 = 5'h07;
  localparam logic [4:0] ADDR_LEN_X8  = 5'h08;
  localparam logic [4:0] DATA_LEN_X16 = 5'h10;
  localparam logic [4:0] DATA_LEN_X8  = 5'h08;
  localparam logic [4:0] OPC_LEN      = 5'h02;
  localparam logic [1:0] OPC_EXT      = 2'h0;
  localparam logic [1:0] OPC_WRITE    = 2'h1;
  localparam logic [1:0] OPC_READ     = 2'h2;
  localparam logic [1:0] OPC_ERASE    = 2'h3;
  localparam logic [1:0] EXT_LOCK     = 2'h0;
  localparam logic [1:0] EXT_FILL     = 2'h1;
  localparam logic [1:0] EXT_CLEAR    = 2'h2;
  localparam logic [1:0] EXT_UNLOCK   = 2'h3;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // ----------------------------------------------------------------
  // pin synchroniser lanes and reset values
  // ----------------------------------------------------------------
  localparam int         LANE_CS    = 0;
  localparam int         LANE_SK    = 1;
  localparam int         LANE_DI    = 2;
  localparam logic [2:0] PINS_RESET = 3'h0;

  typedef enum logic [2:0] {
    S_IDLE, S_OPC, S_ADDR, S_DATA, S_RDUMMY, S_RDATA, S_ARMED, S_HOLD
  } seep_rx_t;

endpackage

// file: verilog/seep_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module seep_sync
  import seep_pkg::*;
#(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pins,
  output logic      [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] stable;
  } seep_sync_t;

  seep_sync_t st_reg;
  seep_sync_t st_next;

  // a change is taken only once the second and third stages agree
  always_comb begin
    st_next        = st_reg;
    st_next.ff1    = pins;
    st_next.ff2    = st_reg.ff1;
    st_next.ff3    = st_reg.ff2;
    st_next.stable = (~(st_reg.ff2 ^ st_reg.ff3) & st_reg.ff3)
                   | ((st_reg.ff2 ^ st_reg.ff3) & st_reg.stable);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.stable;

endmodule // seep_sync

// file: verilog/seep_mem.sv
// word array with byte-lane writes and registered read data
`timescale 1ns/10ps
module seep_mem
  import seep_pkg::*;
#(
  parameter int DEPTH = WORDS
) (
  input  wire logic                     clk,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [1:0]               wr_be,
  input  wire logic [15:0]              wr_data,
  output logic      [15:0]              rd_data
);

  logic [15:0] mem_reg [DEPTH];
  logic [15:0] rd_data_reg;

  // contents survive reset, as a nonvolatile array should
  always_ff @(posedge clk) begin
    if (wr_en && wr_be[1]) begin
      mem_reg[wr_addr][15:8] <= wr_data[15:8];
    end
    if (wr_en && wr_be[0]) begin
      mem_reg[wr_addr][7:0] <= wr_data[7:0];
    end
    rd_data_reg <= mem_reg[rd_addr];
  end

  assign rd_data = rd_data_reg;

endmodule // seep_mem

// file: verilog/seep_port.sv
// serial command port: instruction decode, streamed read, lock and self-timed programming
`timescale 1ns/10ps
module seep_port
  import seep_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic select,
  input  wire logic serial_clock_in,
  input  wire logic serial_in,
  input  wire logic width_select,
  input  wire logic supply_ok,
  output logic      serial_out,
  output logic      serial_out_oe_n,
  output logic      busy,
  output logic      unlocked
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    seep_rx_t    rx;
    logic [4:0]  bitcnt;
    logic [1:0]  opc;
    logic [7:0]  addr;
    logic [15:0] shreg;
    logic        rbit;
    logic        dout;
    logic        oe_n;
    logic        unlocked;
    logic        sk_q;
    logic        cs_q;
    logic [3:0]  cs_low;
    logic        armed;
    logic        show;
    logic        busy;
    logic        walk_on;
    logic [6:0]  walk;
    logic [31:0] timer;
    logic        p_all;
    logic        p_wide;
    logic [7:0]  p_addr;
    logic [15:0] p_data;
  } seep_port_st_t;

  seep_port_st_t st_reg;
  seep_port_st_t st_next;

  logic [2:0]  pins_s;
  logic        cs_s;
  logic        sk_s;
  logic        di_s;
  logic        sk_rise;
  logic        cs_fall;
  logic        cs_rise;
  logic [15:0] rd_data;
  logic        mem_we;
  logic [6:0]  mem_waddr;
  logic [1:0]  mem_be;
  logic [15:0] mem_wdata;
  logic [6:0]  mem_raddr;

  function automatic logic [4:0] addr_len(input logic wide);
    return wide ? ADDR_LEN_X16 : ADDR_LEN_X8;
  endfunction

  function automatic logic [4:0] data_len(input logic wide);
    return wide ? DATA_LEN_X16 : DATA_LEN_X8;
  endfunction

  function automatic logic [6:0] word_of(input logic [7:0] a, input logic wide);
    return wide ? a[6:0] : a[7:1];
  endfunction

  // ----------------------------------------------------------------
  // pins and memory
  // ----------------------------------------------------------------
  seep_sync #(.W(3)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pins  ({serial_in, serial_clock_in, select}),
    .level (pins_s)
  );

  assign cs_s    = pins_s[LANE_CS];
  assign sk_s    = pins_s[LANE_SK];
  assign di_s    = pins_s[LANE_DI];
  assign sk_rise = sk_s & ~st_reg.sk_q & cs_s;
  assign cs_fall = st_reg.cs_q & ~cs_s;
  assign cs_rise = ~st_reg.cs_q & cs_s;

  assign mem_raddr = word_of(st_reg.addr, width_select);
  assign mem_we    = st_reg.walk_on;
  assign mem_waddr = st_reg.p_all ? st_reg.walk : word_of(st_reg.p_addr, st_reg.p_wide);
  assign mem_be    = (st_reg.p_all || st_reg.p_wide) ? 2'h3 : (st_reg.p_addr[0] ? 2'h1 : 2'h2);
  assign mem_wdata = st_reg.p_wide ? st_reg.p_data : {st_reg.p_data[7:0], st_reg.p_data[7:0]};

  seep_mem #(.DEPTH(WORDS)) u_mem (
    .clk     (clk),
    .rd_addr (mem_raddr),
    .wr_en   (mem_we),
    .wr_addr (mem_waddr),
    .wr_be   (mem_be),
    .wr_data (mem_wdata),
    .rd_data (rd_data)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0]  a_new;
    logic [15:0] word;
    logic [1:0]  sub;
    a_new   = {st_reg.addr[6:0], di_s};
    word    = width_select ? rd_data : {(st_reg.addr[0] ? rd_data[7:0] : rd_data[15:8]), 8'h00};
    sub     = width_select ? a_new[6:5] : a_new[7:6];
    st_next = st_reg;
    st_next.sk_q = sk_s;
    st_next.cs_q = cs_s;

    // cs low time, saturating, for the status window
    if (cs_s) begin
      st_next.cs_low = 4'h0;
    end else if (st_reg.cs_low < 4'(CS_LOW_CYCLES)) begin
      st_next.cs_low = st_reg.cs_low + 4'h1;
    end

    // self-timed engine; walks the array for the all-location operations
    if (st_reg.walk_on) begin
      st_next.walk = st_reg.walk + 7'h01;
      if (!st_reg.p_all || st_reg.walk == 7'(WORDS - 1)) begin
        st_next.walk_on = 1'b0;
      end
    end
    if (st_reg.busy) begin
      st_next.timer = st_reg.timer - 32'h1;
      if (st_reg.timer == 32'h1) begin
        st_next.busy = 1'b0;
      end
    end

    // instruction receiver; while selected nothing moves without a clock edge
    if (!cs_s) begin
      st_next.rx     = S_IDLE;
      st_next.bitcnt = 5'h00;
      if (cs_fall && st_reg.rx == S_ARMED && st_reg.unlocked && supply_ok) begin
        st_next.busy    = 1'b1;
        st_next.timer   = 32'(PROG_CYCLES);
        st_next.walk_on = 1'b1;
        st_next.walk    = 7'h00;
        st_next.armed   = 1'b1;
        st_next.show    = 1'b0;
      end
    end else if (sk_rise) begin
      unique case (st_reg.rx)
        S_IDLE: begin
          if (di_s && !st_reg.busy) begin
            st_next.rx     = S_OPC;
            st_next.bitcnt = 5'h00;
            st_next.addr   = 8'h00;
          end
        end
        S_OPC: begin
          st_next.opc    = {st_reg.opc[0], di_s};
          st_next.bitcnt = st_reg.bitcnt + 5'h01;
          if (st_reg.bitcnt == OPC_LEN - 5'h01) begin
            st_next.rx     = S_ADDR;
            st_next.bitcnt = 5'h00;
          end
        end
        S_ADDR: begin
          st_next.addr   = a_new;
          st_next.bitcnt = st_reg.bitcnt + 5'h01;
          if (st_reg.bitcnt == addr_len(width_select) - 5'h01) begin
            st_next.bitcnt = 5'h00;
            st_next.p_addr = a_new;
            st_next.p_wide = width_select;
            st_next.p_all  = 1'b0;
            st_next.p_data = ERASED_WORD;
            unique case (st_reg.opc)
              OPC_READ: begin
                st_next.rx   = S_RDUMMY;
                st_next.rbit = 1'b0;
              end
              OPC_WRITE: st_next.rx = S_DATA;
              OPC_ERASE: st_next.rx = S_ARMED;
              OPC_EXT: begin
                unique case (sub)
                  EXT_UNLOCK: begin
                    st_next.unlocked = 1'b1;
                    st_next.rx       = S_HOLD;
                  end
                  EXT_LOCK: begin
                    st_next.unlocked = 1'b0;
                    st_next.rx       = S_HOLD;
                  end
                  EXT_FILL: begin
                    st_next.p_all = 1'b1;
                    st_next.rx    = S_DATA;
                  end
                  EXT_CLEAR: begin
                    st_next.p_all = 1'b1;
                    st_next.rx    = S_ARMED;
                  end
                endcase
              end
            endcase
          end
        end
        S_DATA: begin
          st_next.p_data = {st_reg.p_data[14:0], di_s};
          st_next.bitcnt = st_reg.bitcnt + 5'h01;
          if (st_reg.bitcnt == 5'h00) begin
            st_next.p_data = {15'h0000, di_s};
          end
          if (st_reg.bitcnt == data_len(st_reg.p_wide) - 5'h01) begin
            st_next.rx = S_ARMED;
          end
        end
        S_RDUMMY, S_RDATA: begin
          st_next.rx = S_RDATA;
          if (st_reg.rx == S_RDUMMY || st_reg.bitcnt == 5'h00) begin
            st_next.rbit   = word[15];
            st_next.shreg  = {word[14:0], 1'b0};
            st_next.bitcnt = data_len(width_select) - 5'h01;
            st_next.addr   = width_select ? {1'b0, st_reg.addr[6:0] + 7'h01}
                                          : st_reg.addr + 8'h01;
          end else begin
            st_next.rbit   = st_reg.shreg[15];
            st_next.shreg  = {st_reg.shreg[14:0], 1'b0};
            st_next.bitcnt = st_reg.bitcnt - 5'h01;
          end
        end
        S_ARMED: st_next.rx = S_HOLD;
        S_HOLD:  st_next.rx = S_HOLD;
      endcase
    end

    // status display; the clearing combination wins over a rise in the same cycle
    if (cs_rise && st_reg.armed && st_reg.cs_low >= 4'(CS_LOW_CYCLES)) begin
      st_next.show = 1'b1;
    end
    if (sk_rise && di_s) begin
      st_next.show  = 1'b0;
      st_next.armed = 1'b0;
    end

    st_next.oe_n = ~(cs_s && (st_next.show || st_next.rx == S_RDUMMY
                   || st_next.rx == S_RDATA));
    st_next.dout = st_next.show ? ~st_next.busy : st_next.rbit;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg      <= '0;
      st_reg.rx   <= S_IDLE;
      st_reg.oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign serial_out      = st_reg.dout;
  assign serial_out_oe_n = st_reg.oe_n;
  assign busy            = st_reg.busy;
  assign unlocked        = st_reg.unlocked;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_hiz_deselect: assert property (
    @(posedge clk) disable iff (!rst_n) !cs_s |=> serial_out_oe_n)
    else $error("output driven while deselected");

  a_locked_refuse: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cs_fall && !st_reg.unlocked && !st_reg.busy) |=> !st_reg.busy)
    else $error("programming started while locked");

  a_supply_refuse: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cs_fall && !supply_ok && !st_reg.busy) |=> !st_reg.busy)
    else $error("programming started with low supply");

  a_prog_start: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cs_fall && st_reg.rx == S_ARMED && st_reg.unlocked && supply_ok)
    |=> (st_reg.busy && st_reg.walk_on))
    else $error("armed instruction did not start programming");

  a_status_level: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_reg.show && !serial_out_oe_n) |-> (serial_out == !st_reg.busy))
    else $error("status output disagrees with busy");

  a_status_clear: assert property (
    @(posedge clk) disable iff (!rst_n) (sk_rise && di_s) |=> !st_reg.show)
    else $error("status display not cleared");

  a_dummy_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_reg.rx == S_RDUMMY && !serial_out_oe_n) |-> !serial_out)
    else $error("dummy bit is not zero");

  a_static_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_reg.rx == S_RDATA && cs_s && !sk_rise)
    |=> ($stable(st_reg.shreg) && $stable(st_reg.addr)))
    else $error("read state moved without a clock edge");

  a_lock_at_reset: assert property (
    @(posedge clk) !rst_n |=> (!st_reg.unlocked && !st_reg.busy))
    else $error("not locked after reset");

endmodule // seep_port

// file: test/seep_host.sv
// host side model driving select, serial clock and serial data of the command port
`timescale 1ns/10ps
module seep_host (
  input  wire logic clk,
  input  wire logic serial_out,
  input  wire logic serial_out_oe_n,
  output logic      select,
  output logic      serial_clock_in,
  output logic      serial_in
);
  // a released output shows the inverse of its last level, so a missing enable is caught
  logic so_line;
  assign so_line = serial_out_oe_n ? ~serial_out : serial_out;
  initial begin
    select = 1'b0;
    serial_clock_in = 1'b0;
    serial_in = 1'b0;
  end
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // half period of 10 clk leaves margin over the pin filter delay
  task automatic bit_io(input logic d, output logic q);
    serial_in = d;
    wclk(10);
    serial_clock_in = 1'b1;
    wclk(10);
    q = so_line;
    serial_clock_in = 1'b0;
  endtask
  task automatic cmd(input logic [1:0] op, input logic [7:0] a, input int alen,
                     output logic q);
    select = 1'b1;
    wclk(4);
    bit_io(1'b0, q);
    bit_io(1'b1, q);
    for (int i = 1; i >= 0; i--) bit_io(op[i], q);
    for (int i = alen - 1; i >= 0; i--) bit_io(a[i], q);
  endtask
  task automatic shift_out(input logic [15:0] d, input int n);
    logic q;
    for (int i = n - 1; i >= 0; i--) bit_io(d[i], q);
  endtask
  task automatic sel_up();
    select = 1'b1;
    wclk(10);
  endtask
  // clock stays low between frames; data line shows the inverse of its last level
  task automatic fin();
    select = 1'b0;
    serial_in = ~serial_in;
    wclk(20);
  endtask
endmodule // seep_host

// file: test/serial_eeprom_command_port_bench.sv
// self-checking bench of the serial command port, driven through the host model
`timescale 1ns/10ps
module serial_eeprom_command_port_bench
  import seep_pkg::*;
;
  localparam int PROG_SIM = 200;
  logic clk;
  logic rst_n;
  logic width_select;
  logic supply_ok;
  logic select;
  logic serial_clock_in;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe_n;
  logic busy;
  logic unlocked;
  int   fail_count = 0;
  int   n_checks   = 0;

  seep_port #(.PROG_CYCLES(PROG_SIM)) uut (
    .clk             (clk),
    .rst_n           (rst_n),
    .select          (select),
    .serial_clock_in (serial_clock_in),
    .serial_in       (serial_in),
    .width_select    (width_select),
    .supply_ok       (supply_ok),
    .serial_out      (serial_out),
    .serial_out_oe_n (serial_out_oe_n),
    .busy            (busy),
    .unlocked        (unlocked)
  );
  seep_host host (
    .clk             (clk),
    .serial_out      (serial_out),
    .serial_out_oe_n (serial_out_oe_n),
    .select          (select),
    .serial_clock_in (serial_clock_in),
    .serial_in       (serial_in)
  );

  initial clk = 1'b0;
  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      host.wclk(1);
      n++;
    end
    chk("busy released", 16'h0, {15'h0, busy});
  endtask
  task automatic prog(input logic [1:0] op, input logic [7:0] a, input logic [15:0] d,
                      input int dn, input logic exp_busy);
    logic q;
    host.cmd(op, a, width_select ? 7 : 8, q);
    host.shift_out(d, dn);
    chk("oe_n in program command", 16'h1, {15'h0, serial_out_oe_n});
    host.fin();
    chk("busy after select fall", {15'h0, exp_busy}, {15'h0, busy});
    wait_idle();
  endtask
  task automatic ext(input logic [1:0] sub, input logic [15:0] d, input int dn,
                     input logic exp_busy);
    prog(OPC_EXT, {1'b0, sub, 5'h00}, d, dn, exp_busy);
  endtask
  task automatic rd(input logic [7:0] a, input int alen, input int w,
                    input logic [15:0] e0, input logic [15:0] e1);
    logic        q;
    logic [15:0] v;
    host.cmd(OPC_READ, a, alen, q);
    chk("dummy bit", 16'h0, {15'h0, q});
    for (int k = 0; k < 2; k++) begin
      v = 16'h0;
      for (int i = 0; i < w; i++) begin
        host.bit_io(1'b0, q);
        v = {v[14:0], q};
      end
      chk("read word", (k == 0) ? e0 : e1, v);
      host.wclk(60);
    end
    host.fin();
    chk("oe_n after deselect", 16'h1, {15'h0, serial_out_oe_n});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("unlocked at reset", 16'h0, {15'h0, unlocked});
    chk("busy at reset", 16'h0, {15'h0, busy});
    chk("oe_n at reset", 16'h1, {15'h0, serial_out_oe_n});
  endtask
  task automatic t_guard();
    logic q;
    prog(OPC_WRITE, 8'h03, 16'h1111, 16, 1'b0);
    ext(EXT_UNLOCK, 16'h0, 0, 1'b0);
    chk("unlocked", 16'h1, {15'h0, unlocked});
    supply_ok = 1'b0;
    prog(OPC_WRITE, 8'h03, 16'h1111, 16, 1'b0);
    supply_ok = 1'b1;
    // one clock rise too many before select falls discards the write
    host.cmd(OPC_WRITE, 8'h03, 7, q);
    host.shift_out(16'h1111, 16);
    host.bit_io(1'b0, q);
    host.fin();
    chk("busy after late select fall", 16'h0, {15'h0, busy});
  endtask
  // top address with a following write at zero sets up the wrap check
  task automatic t_status();
    logic q;
    host.cmd(OPC_WRITE, 8'h7F, 7, q);
    host.shift_out(16'hA5C3, 16);
    host.fin();
    host.sel_up();
    chk("status oe_n", 16'h0, {15'h0, serial_out_oe_n});
    chk("status busy", 16'h0, {15'h0, host.so_line});
    wait_idle();
    host.wclk(8);
    chk("status ready", 16'h1, {15'h0, host.so_line});
    host.bit_io(1'b1, q);
    chk("status cleared", 16'h1, {15'h0, serial_out_oe_n});
    host.fin();
    prog(OPC_WRITE, 8'h00, 16'h3C5A, 16, 1'b1);
  endtask
  task automatic t_stream();
    ext(EXT_LOCK, 16'h0, 0, 1'b0);
    chk("locked", 16'h0, {15'h0, unlocked});
    rd(8'h7F, 7, 16, 16'hA5C3, 16'h3C5A);
    width_select = 1'b0;
    rd(8'hFE, 8, 8, 16'h00A5, 16'h00C3);
    width_select = 1'b1;
  endtask
  task automatic t_erase_all();
    ext(EXT_UNLOCK, 16'h0, 0, 1'b0);
    prog(OPC_ERASE, 8'h00, 16'h0, 0, 1'b1);
    rd(8'h7F, 7, 16, 16'hA5C3, 16'hFFFF);
    ext(EXT_FILL, 16'h1234, 16, 1'b1);
    rd(8'h7F, 7, 16, 16'h1234, 16'h1234);
    ext(EXT_CLEAR, 16'h0, 0, 1'b1);
    rd(8'h7F, 7, 16, 16'hFFFF, 16'hFFFF);
    ext(EXT_LOCK, 16'h0, 0, 1'b0);
  endtask
  // a byte write on the narrow organisation touches one half of a word only
  task automatic t_narrow();
    ext(EXT_UNLOCK, 16'h0, 0, 1'b0);
    width_select = 1'b0;
    prog(OPC_WRITE, 8'h01, 16'h005A, 8, 1'b1);
    rd(8'h00, 8, 8, 16'h00FF, 16'h005A);
    width_select = 1'b1;
    ext(EXT_LOCK, 16'h0, 0, 1'b0);
  endtask

  initial begin
    rst_n = 1'b0;
    width_select = 1'b1;
    supply_ok = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    host.wclk(6);
    t_reset();
    t_guard();
    t_status();
    t_stream();
    t_erase_all();
    t_narrow();
    tally_and_finish();
  end

  // the run needs about 12400 clk; the limit allows a few times that
  initial begin
    #1000000;
    fail_count++;
    $display("unexpected watchdog expiry: expected done, seen hang");
    tally_and_finish();
  end
endmodule // serial_eeprom_command_port_bench
